// file: common/fault_ack_regs.svh
// Purpose: Offsets, field positions, reset values and timing for the fault manager
// Assumes: 32-bit APB data, one register to an aligned word
// Notes: Definitions only
`ifndef FAULT_ACK_REGS_SVH
`define FAULT_ACK_REGS_SVH
`define ADDR_CTRL 8'h00
`define ADDR_EVENT 8'h04
`define ADDR_CAUSE 8'h08
`define ADDR_SEVCFG 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_DISP 8'h14
`define ADDR_FW 8'h18
`define ADDR_NODE 8'h1c
`define CTRL_ACK 0
`define CTRL_START 1
`define CTRL_NODE_RDY 2
`define CTRL_INIT_DONE 3
`define CTRL_RESTART 4
`define CTRL_HOMED 5
`define CTRL_W 6
`define CTRL_RESET 6'h00
`define EV_MSG_LSB 0
`define EV_GRP_LSB 4
`define EV_STEP_LSB 8
`define EV_RTYPE_LSB 10
`define EV_CFG_BIT 12
`define EV_ENC_BIT 13
`define CAUSE_WARN_BIT 9
`define FW_PROG_LSB 8
`define ERR_CODE_BASE 8'h64
`define CH_E 8'h45
`define CH_F 8'h46
`define CH_U 8'h55
`define CH_P 8'h50
`define CH_D 8'h64
`define CH_0 8'h30
`define CH_8 8'h38
`define CH_BLANK 8'h20
`define CH_DASH 8'h2d
`define CLK_HZ 10000000
`define REINIT_MS 3000
`define FLASH_MS 500
`endif

// file: common/fault_ack_pkg.sv
// Purpose: Types shared by the fault manager and its bench
// Assumes: Nothing
// Notes: Step codes are ordered by severity
package fault_ack_pkg;
  typedef enum logic [1:0] {
    STEP_WARN = 2'b00, STEP_ONE = 2'b01, STEP_TWO = 2'b10, STEP_SYS = 2'b11
  } step_t;
  typedef enum logic [1:0] {
    RT_RESET = 2'b00, RT_FIXED = 2'b01, RT_REINIT = 2'b10, RT_POFF = 2'b11
  } rtype_t;
  typedef enum logic [2:0] {
    FW_IDLE = 3'b000, FW_LOAD = 3'b001, FW_DECOMP = 3'b010, FW_PROG = 3'b011,
    FW_DONE = 3'b100, FW_DECOMP_ERR = 3'b101, FW_PROG_ERR = 3'b110
  } fw_phase_t;
  typedef enum logic {REC_IDLE = 1'b0, REC_REINIT = 1'b1} rec_t;
endpackage

// file: rtl/axis_fault_ack_manager.sv
// Purpose: Fault and warning handling, acknowledgement and status display of an axis
// Assumes: Software on APB mirrors the cyclic I/O bits and reports diagnostic events
// Notes: One pending fault per message group; display shows the lowest pending group
// What this block does
// [RQ1] A fault lights the fault LED, shows E and sets the fault bit; a system fault here leaves the fault bit at its old value.
// [RQ2] A warning sets the warning bit and leaves sequence and axis alone.
// [RQ3] A pending fault blocks new positioning until acknowledged.
// [RQ4] Step-one fault: fault state, axis stopped, fault bit set.
// [RQ5] Step-two fault: fault state, controller off, drive blocked, fault bit set.
// [RQ6] Step-two fault with encoder link loss clears the homed flag.
// [RQ7] System fault halts everything and freezes fault and warning bits.
// [RQ8] Controller acknowledges by a rising edge, waits 3 s, checks the fault bit.
// [RQ9] Each acknowledge edge tries all pending faults; worst step governs behaviour.
// [RQ10] If some faults remain after acknowledge, one remaining fault is shown.
// [RQ11] Plain reset faults clear on acknowledge unconditionally.
// [RQ12] Reset-if-fixed faults clear only when their cause is gone.
// [RQ13] Reinitialise faults restart components within 3 s, clear if no new fault.
// [RQ14] Reinitialise recovery loses homing; homing must run again.
// [RQ15] Power-off faults ignore acknowledge; only power cycle or restart clears.
// [RQ16] Warning bit clears on start edge, or acknowledge edge with cause gone.
// [RQ17] Diagnostic numbers are two digits: group then message.
// [RQ18] Bus node gets only the group, as code 100 plus group digit.
// [RQ19] Configurable messages switch between warning and fault from factory step.
// [RQ20] System initialisation shows eights; bus node initialisation shows blank.
// [RQ21] Firmware load flashes point with progress, then decompress, program, done codes.
// [RQ22] A failing firmware phase shows E with that phase code.
// [RQ23] An active fault shows E with its two-digit error number.
// [RQ24] Request edges come from comparing each sample with the previous one.
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`include "fault_ack_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module axis_fault_ack_manager
  import fault_ack_pkg::*;
#(
  parameter int unsigned NG = 9,
  parameter int unsigned REINIT_CYCLES = `CLK_HZ / 1000 * `REINIT_MS,
  parameter int unsigned FLASH_CYCLES = `CLK_HZ / 1000 * `FLASH_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic fault_led,
  output logic fault_status_bit,
  output logic warning_status_bit,
  output logic homed_flag,
  output logic seq_fault,
  output logic axis_stop,
  output logic drive_block,
  output logic system_halted,
  output logic reinit_req,
  output logic start_grant,
  output logic [7:0] node_error_code,
  output logic node_error_valid,
  output logic [7:0] disp_status,
  output logic [7:0] disp_info_hi,
  output logic [7:0] disp_info_lo,
  output logic disp_point
);

  logic [`CTRL_W-1:0] ctrl;
  logic [`CTRL_W-1:0] ctrl_prev;
  logic [`CTRL_W-1:0] ctrl_edge;
  logic [NG-1:0] sevcfg;
  logic [NG-1:0] f_valid;
  logic [NG-1:0] f_cause;
  logic [NG-1:0] reinit_mask;
  logic [3:0] f_msg [NG];
  step_t f_step [NG];
  rtype_t f_rtype [NG];
  step_t worst;
  step_t ev_step;
  fw_phase_t fw_phase;
  logic [6:0] fw_prog;
  rec_t rec;
  logic [31:0] rec_cnt;
  logic [31:0] flash_cnt;
  logic blink;
  logic new_fault;
  logic halted;
  logic warn_cause;
  logic [3:0] warn_grp;
  logic [3:0] warn_msg;
  logic [3:0] ev_grp;
  logic any_fault;
  logic wr_en;
  logic setup;
  logic log_event;
  logic log_fault;
  logic halt_now;
  logic reinit_start;
  logic reinit_end;
  logic [3:0] show_grp;
  logic [31:0] next_rdata;

  // Lowest pending group; any remaining fault may be shown
  function automatic logic [3:0] first_valid(input logic [NG-1:0] m);
    first_valid = 4'h0;
    for (int i = NG - 1; i >= 0; i--) begin
      if (m[i]) first_valid = 4'(i);
    end
  endfunction

  // Decimal digit to display character
  function automatic logic [7:0] dec_char(input logic [3:0] d);
    dec_char = `CH_0 + {4'h0, d};
  endfunction

  // Configured alternative swaps warning and fault
  function automatic step_t eff_step(input step_t f, input logic cfg, input logic alt);
    if (cfg && alt) begin
      eff_step = (f == STEP_WARN) ? STEP_ONE : STEP_WARN; // see [RQ19]
    end else begin
      eff_step = f;
    end
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `ADDR_CTRL) || (a == `ADDR_EVENT) || (a == `ADDR_CAUSE) ||
              (a == `ADDR_SEVCFG) || (a == `ADDR_STATUS) || (a == `ADDR_DISP) ||
              (a == `ADDR_FW) || (a == `ADDR_NODE);
  endfunction

  // Bus phases; writes land at the access edge, never while halted
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && !halted && addr_ok(paddr);
  assign ev_grp = pwdata[`EV_GRP_LSB +: 4];
  assign ev_step = eff_step(step_t'(pwdata[`EV_STEP_LSB +: 2]), pwdata[`EV_CFG_BIT],
                            (ev_grp < 4'(NG)) ? sevcfg[ev_grp] : 1'b0);
  assign log_event = wr_en && (paddr == `ADDR_EVENT) && (ev_grp < 4'(NG));
  assign log_fault = log_event && (ev_step != STEP_WARN);
  assign halt_now = log_fault && (ev_step == STEP_SYS); // see [RQ7]
  assign ctrl_edge = ctrl & ~ctrl_prev; // see [RQ24]
  assign any_fault = |f_valid;
  assign show_grp = first_valid(f_valid); // see [RQ10]

  // Faults that want a reinitialisation on acknowledge
  always_comb begin
    reinit_mask = '0;
    worst = STEP_WARN;
    for (int i = 0; i < NG; i++) begin
      reinit_mask[i] = f_valid[i] && (f_rtype[i] == RT_REINIT);
      if (f_valid[i] && (f_step[i] > worst)) worst = f_step[i]; // see [RQ9]
    end
  end

  assign reinit_start = ctrl_edge[`CTRL_ACK] && (rec == REC_IDLE) && (|reinit_mask);
  assign reinit_end = (rec == REC_REINIT) && (rec_cnt == 32'h0);

  // APB answer: data captured in setup, pready high for the single access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !addr_ok(paddr);
      if (setup) prdata <= pwrite ? 32'h0 : next_rdata;
    end
  end

  // Read mux; write-only registers read as zero
  always_comb begin
    next_rdata = 32'h0;
    unique case (paddr)
      `ADDR_CTRL: next_rdata = {26'h0, ctrl};
      `ADDR_SEVCFG: next_rdata = {{(32 - NG){1'b0}}, sevcfg};
      `ADDR_STATUS: next_rdata = {16'h0, 4'(worst), show_grp, rec == REC_REINIT, halted,
                                  drive_block, axis_stop, seq_fault, homed_flag,
                                  warning_status_bit, fault_status_bit};
      `ADDR_DISP: next_rdata = {7'h0, disp_point, disp_status, disp_info_hi, disp_info_lo};
      `ADDR_FW: next_rdata = {17'h0, fw_prog, 5'h0, fw_phase};
      `ADDR_NODE: next_rdata = {23'h0, node_error_valid, node_error_code};
      default: next_rdata = 32'h0;
    endcase
  end

  // Request bits and their previous sample; edges are one cycle after the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      ctrl_prev <= `CTRL_RESET;
      sevcfg <= '0;
      fw_phase <= FW_IDLE;
      fw_prog <= 7'h00;
    end else begin
      ctrl_prev <= ctrl; // see [RQ24]
      if (wr_en && paddr == `ADDR_CTRL) ctrl <= pwdata[`CTRL_W-1:0];
      if (wr_en && paddr == `ADDR_SEVCFG) sevcfg <= pwdata[NG-1:0];
      if (wr_en && paddr == `ADDR_FW) begin
        fw_phase <= fw_phase_t'(pwdata[2:0]);
        fw_prog <= (pwdata[`FW_PROG_LSB +: 7] > 7'd99) ? 7'd99 : pwdata[`FW_PROG_LSB +: 7];
      end
    end
  end

  // Fault table; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_valid <= '0;
      f_cause <= '0;
      for (int i = 0; i < NG; i++) begin
        f_msg[i] <= 4'h0;
        f_step[i] <= STEP_WARN;
        f_rtype[i] <= RT_RESET;
      end
    end else if (!halted) begin
      if (ctrl_edge[`CTRL_RESTART]) begin
        f_valid <= '0; // see [RQ15]
      end else begin
        for (int i = 0; i < NG; i++) begin
          if (ctrl_edge[`CTRL_ACK] && f_valid[i]) begin // see [RQ9]
            if (f_rtype[i] == RT_RESET) f_valid[i] <= 1'b0; // see [RQ11]
            if (f_rtype[i] == RT_FIXED && !f_cause[i]) f_valid[i] <= 1'b0; // see [RQ12]
          end
          if (reinit_end && !new_fault && f_rtype[i] == RT_REINIT) begin
            f_valid[i] <= 1'b0; // see [RQ13]
          end
        end
      end
      if (wr_en && paddr == `ADDR_CAUSE) f_cause <= f_cause & ~pwdata[NG-1:0];
      if (log_fault) begin
        f_valid[ev_grp] <= 1'b1;
        f_cause[ev_grp] <= 1'b1;
        f_msg[ev_grp] <= pwdata[`EV_MSG_LSB +: 4]; // see [RQ17]
        f_step[ev_grp] <= ev_step;
        f_rtype[ev_grp] <= rtype_t'(pwdata[`EV_RTYPE_LSB +: 2]);
      end
    end
  end

  // Reinitialisation timer; any fault during it keeps the fault state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec <= REC_IDLE;
      rec_cnt <= 32'h0;
      new_fault <= 1'b0;
      reinit_req <= 1'b0;
    end else if (!halted) begin
      unique case (rec)
        REC_IDLE: begin
          if (reinit_start) begin // see [RQ13]
            rec <= REC_REINIT;
            rec_cnt <= REINIT_CYCLES - 1;
            new_fault <= 1'b0;
            reinit_req <= 1'b1;
          end
        end
        REC_REINIT: begin
          if (log_fault) new_fault <= 1'b1;
          if (ctrl_edge[`CTRL_RESTART] || reinit_end) begin
            rec <= REC_IDLE;
            reinit_req <= 1'b0;
          end else begin
            rec_cnt <= rec_cnt - 32'h1;
          end
        end
      endcase
    end
  end

  // Homing state; lost by reinitialisation or by encoder link loss on a step-two fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      homed_flag <= 1'b0;
    end else if (!halted) begin
      if (reinit_start) begin
        homed_flag <= 1'b0; // see [RQ14]
      end else if (log_fault && ev_step == STEP_TWO && pwdata[`EV_ENC_BIT]) begin
        homed_flag <= 1'b0; // see [RQ6]
      end else if (ctrl_edge[`CTRL_HOMED] && !any_fault) begin
        homed_flag <= 1'b1;
      end
    end
  end

  // Warnings touch nothing but their own bit and the group report to the bus node
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warning_status_bit <= 1'b0;
      warn_cause <= 1'b0;
      warn_grp <= 4'h0;
      warn_msg <= 4'h0;
    end else if (!halted && !halt_now) begin // see [RQ7]
      if (ctrl_edge[`CTRL_START] || ctrl_edge[`CTRL_RESTART]) begin
        warning_status_bit <= 1'b0; // see [RQ16]
      end else if (ctrl_edge[`CTRL_ACK] && !warn_cause) begin
        warning_status_bit <= 1'b0; // see [RQ16]
      end
      if (wr_en && paddr == `ADDR_CAUSE && pwdata[`CAUSE_WARN_BIT]) warn_cause <= 1'b0;
      if (log_event && ev_step == STEP_WARN) begin
        warning_status_bit <= 1'b1; // see [RQ2]
        warn_cause <= 1'b1;
        warn_grp <= ev_grp;
        warn_msg <= pwdata[`EV_MSG_LSB +: 4];
      end
    end
  end

  // Severity outputs; a system fault freezes the status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted <= 1'b0;
      system_halted <= 1'b0;
      fault_status_bit <= 1'b0;
      fault_led <= 1'b0;
      seq_fault <= 1'b0;
      axis_stop <= 1'b0;
      drive_block <= 1'b0;
      start_grant <= 1'b0;
    end else begin
      if (halt_now) halted <= 1'b1; // see [RQ7]
      system_halted <= halted || halt_now;
      fault_led <= any_fault; // see [RQ1]
      if (!halted && !halt_now) begin
        fault_status_bit <= any_fault; // see [RQ1]
        seq_fault <= any_fault; // see [RQ4]
        axis_stop <= worst >= STEP_ONE; // see [RQ4]
        drive_block <= (worst >= STEP_TWO) || (rec == REC_REINIT) || reinit_start; // see [RQ5]
      end
      // Start passes only with no fault pending and no recovery running
      start_grant <= ctrl_edge[`CTRL_START] && !any_fault && !halted &&
                     (rec == REC_IDLE); // see [RQ3]
    end
  end

  // Group report to the bus node
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_error_code <= 8'h00;
      node_error_valid <= 1'b0;
    end else begin
      node_error_valid <= any_fault || warning_status_bit;
      node_error_code <= `ERR_CODE_BASE + {4'h0, any_fault ? show_grp : warn_grp}; // see [RQ18]
    end
  end

  // Blink timer for the point segment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt <= 32'h0;
      blink <= 1'b0;
    end else if (flash_cnt >= FLASH_CYCLES - 1) begin
      flash_cnt <= 32'h0;
      blink <= !blink;
    end else begin
      flash_cnt <= flash_cnt + 32'h1;
    end
  end

  // Display; faults first, then initialisation, then firmware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_status <= `CH_BLANK;
      disp_info_hi <= `CH_BLANK;
      disp_info_lo <= `CH_BLANK;
      disp_point <= 1'b0;
    end else begin
      disp_point <= 1'b0;
      if (!ctrl[`CTRL_NODE_RDY] && !any_fault) begin
        disp_status <= `CH_BLANK; // see [RQ20]
        disp_info_hi <= `CH_BLANK;
        disp_info_lo <= `CH_BLANK;
      end else if (!ctrl[`CTRL_INIT_DONE] && !any_fault) begin
        disp_status <= `CH_8; // see [RQ20]
        disp_info_hi <= `CH_8;
        disp_info_lo <= `CH_8;
      end else if (any_fault) begin
        disp_status <= `CH_E; // see [RQ23]
        disp_info_hi <= dec_char(show_grp);
        disp_info_lo <= dec_char(f_msg[show_grp]);
      end else begin
        unique case (fw_phase)
          FW_LOAD: begin
            disp_point <= blink; // see [RQ21]
            disp_status <= `CH_BLANK;
            disp_info_hi <= dec_char(4'(fw_prog / 7'd10));
            disp_info_lo <= dec_char(4'(fw_prog % 7'd10));
          end
          FW_DECOMP, FW_PROG: begin
            disp_point <= blink; // see [RQ21]
            disp_status <= `CH_BLANK;
            disp_info_hi <= (fw_phase == FW_DECOMP) ? `CH_U : `CH_P;
            disp_info_lo <= `CH_D;
          end
          FW_DECOMP_ERR, FW_PROG_ERR: begin
            disp_status <= `CH_E; // see [RQ22]
            disp_info_hi <= (fw_phase == FW_DECOMP_ERR) ? `CH_U : `CH_P;
            disp_info_lo <= `CH_D;
          end
          FW_DONE: begin
            disp_status <= `CH_F; // see [RQ21]
            disp_info_hi <= `CH_F;
            disp_info_lo <= `CH_U;
          end
          FW_IDLE: begin
            disp_status <= `CH_DASH;
            disp_info_hi <= `CH_DASH;
            disp_info_lo <= `CH_DASH;
          end
          default: begin
            disp_status <= `CH_DASH;
            disp_info_hi <= `CH_DASH;
            disp_info_lo <= `CH_DASH;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// file: test/axis_fault_ack_manager_assertions.sv
// Purpose: Port-level checks of the fault manager
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound into every instance of the top module
`include "fault_ack_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module axis_fault_ack_checker #(
  parameter int unsigned REINIT_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic fault_led,
  input wire logic fault_status_bit,
  input wire logic warning_status_bit,
  input wire logic homed_flag,
  input wire logic seq_fault,
  input wire logic axis_stop,
  input wire logic drive_block,
  input wire logic system_halted,
  input wire logic reinit_req,
  input wire logic start_grant,
  input wire logic [7:0] node_error_code,
  input wire logic node_error_valid,
  input wire logic [7:0] disp_status
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned reinit_cnt;
  // Length of the reinit window, so an off-by-one count shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) reinit_cnt <= 0;
    else if (reinit_req) reinit_cnt <= reinit_cnt + 1;
    else reinit_cnt <= 0;
  end
  // Event writes that land; configurable messages left out as their step may move
  sequence ev_wr;
    psel && penable && pready && pwrite && paddr == `ADDR_EVENT && !system_halted
      && pwdata[7:4] <= 4'd8 && !pwdata[12];
  endsequence
  sequence ev_fault;
    ev_wr ##0 (pwdata[9:8] == 2'd1 || pwdata[9:8] == 2'd2);
  endsequence
  sequence ev_warn;
    ev_wr ##0 pwdata[9:8] == 2'd0;
  endsequence
  a_apb_one_wait: assert property (psel && !penable |=> pready)
    else $error("pready late after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_fault_ev_flags: assert property (ev_fault |-> ##2 (fault_led && fault_status_bit))
    else $error("fault event not flagged");
  a_warn_ev_flag: assert property (ev_warn |-> ##2 warning_status_bit)
    else $error("warning event not flagged");
  a_fault_stops_axis: assert property (fault_status_bit && !system_halted |->
    seq_fault && axis_stop && disp_status == `CH_E)
    else $error("fault without stop or display");
  a_start_refused: assert property (start_grant |-> !fault_status_bit && !reinit_req)
    else $error("start granted while blocked");
  a_node_code_range: assert property (node_error_valid |->
    node_error_code >= 8'h64 && node_error_code <= 8'h6c)
    else $error("node code out of range");
  a_reinit_coast: assert property (reinit_req |-> drive_block && !homed_flag)
    else $error("reinit without block or homing loss");
  a_reinit_len: assert property ($fell(reinit_req) |-> reinit_cnt == REINIT_CYCLES)
    else $error("reinit length wrong");
  a_halt_frozen: assert property (system_halted && $past(system_halted) |->
    $stable(fault_status_bit) && $stable(warning_status_bit))
    else $error("status bits moved after halt");
endmodule
bind axis_fault_ack_manager axis_fault_ack_checker #(.REINIT_CYCLES(REINIT_CYCLES)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .fault_led(fault_led),
  .fault_status_bit(fault_status_bit), .warning_status_bit(warning_status_bit),
  .homed_flag(homed_flag), .seq_fault(seq_fault), .axis_stop(axis_stop),
  .drive_block(drive_block), .system_halted(system_halted), .reinit_req(reinit_req),
  .start_grant(start_grant), .node_error_code(node_error_code),
  .node_error_valid(node_error_valid), .disp_status(disp_status));
`default_nettype wire

// file: test/io_controller.sv
// Purpose: Controller model driving the mirrored I/O bits over APB
// Assumes: Slave answers with pready; no fixed latency assumed
// Notes: Released lines show inverted data so stale values are not trusted
`timescale 1ns/100ps
`default_nettype none
module io_controller (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int n_hang = 0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One APB transfer, held until pready is sampled high or 50 edges have passed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_hang++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // Acknowledge or start is a 0-1-0 pulse so each use makes a fresh edge
  task automatic pulse(input logic [31:0] base, input logic [31:0] bits);
    logic [31:0] q;
    logic e;
    xfer(1'b1, `ADDR_CTRL, base | bits, q, e);
    xfer(1'b1, `ADDR_CTRL, base, q, e);
  endtask
endmodule
`default_nettype wire

// file: test/axis_fault_ack_manager_tb.sv
// Purpose: Self-checking bench for the fault manager
// Assumes: Reinit window shortened to 20 cycles
// Notes: Status is sampled three edges after each write lands
`include "fault_ack_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module axis_fault_ack_manager_tb
  import fault_ack_pkg::*;
;
  localparam logic [31:0] B = 32'h0000000c;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, fault_led, fault_status_bit;
  logic warning_status_bit, homed_flag, seq_fault, axis_stop, drive_block;
  logic system_halted, reinit_req, start_grant, node_error_valid, disp_point;
  logic [7:0] paddr, node_error_code, disp_status, disp_info_hi, disp_info_lo;
  logic [31:0] pwdata, prdata, q;
  logic e;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [7:0] fh [5] = '{`CH_U, `CH_P, `CH_F, `CH_U, `CH_P};
  logic [7:0] fl [5] = '{`CH_D, `CH_D, `CH_U, `CH_D, `CH_D};
  logic [7:0] fs [3] = '{`CH_F, `CH_E, `CH_E};
  // Clock of 100 ns
  always #50 pclk = ~pclk;
  axis_fault_ack_manager #(.REINIT_CYCLES(20), .FLASH_CYCLES(4)) i_axis_fault_ack_manager (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_led(fault_led), .fault_status_bit(fault_status_bit),
    .warning_status_bit(warning_status_bit), .homed_flag(homed_flag), .seq_fault(seq_fault),
    .axis_stop(axis_stop), .drive_block(drive_block), .system_halted(system_halted),
    .reinit_req(reinit_req), .start_grant(start_grant), .node_error_code(node_error_code),
    .node_error_valid(node_error_valid), .disp_status(disp_status),
    .disp_info_hi(disp_info_hi), .disp_info_lo(disp_info_lo), .disp_point(disp_point));
  io_controller i_io_controller (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic complete_run;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_io_controller.xfer(1'b1, a, d, q, e);
  endtask
  // Status lands two edges after the write; the third edge reads it settled
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask
  task automatic fev(input logic [3:0] g, input logic [3:0] m, input step_t s,
                     input rtype_t r, input logic enc);
    wr(`ADDR_EVENT, {18'h0, enc, 1'b0, r, s, g, m});
    settle;
  endtask
  task automatic ack;
    i_io_controller.pulse(B, 32'h1);
    settle;
  endtask
  // Watchdog: a hang counts as a mismatch and still reaches the verdict
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk("blank", `CH_BLANK, disp_status);
    i_io_controller.xfer(1'b0, 8'h40, 32'h0, q, e);
    chk("slverr", 32'h1, e);
    wr(`ADDR_CTRL, 32'h4);
    settle;
    chk("init", `CH_8, disp_info_hi);
    wr(`ADDR_CTRL, B);
    for (int i = 0; i < 5; i++) begin
      wr(`ADDR_FW, i + 2);
      settle;
      chk("fw hi", fh[i], disp_info_hi);
      chk("fw lo", fl[i], disp_info_lo);
      if (i >= 2) chk("fw st", fs[i-2], disp_status);
    end
    wr(`ADDR_FW, 32'h0);
    $display("display test done");
    fev(4'd3, 4'd1, STEP_WARN, RT_RESET, 1'b0);
    chk("warn", 32'h1, warning_status_bit);
    chk("stop", 32'h0, axis_stop);
    chk("code", 32'h67, node_error_code);
    i_io_controller.pulse(B, 32'h2);
    settle;
    chk("warn clr", 32'h0, warning_status_bit);
    fev(4'd2, 4'd5, STEP_ONE, RT_RESET, 1'b0);
    chk("fault", 32'h1, fault_status_bit);
    chk("coast", 32'h0, drive_block);
    chk("digit hi", 32'h32, disp_info_hi);
    chk("digit lo", 32'h35, disp_info_lo);
    chk("code", 32'h66, node_error_code);
    ack;
    chk("reset type", 32'h0, fault_status_bit);
    $display("single fault test done");
    fev(4'd1, 4'd2, STEP_ONE, RT_RESET, 1'b0);
    fev(4'd6, 4'd3, STEP_TWO, RT_FIXED, 1'b0);
    chk("worst", 32'h1, drive_block);
    ack;
    chk("fixed", 32'h1, fault_status_bit);
    chk("remain", 32'h36, disp_info_hi);
    wr(`ADDR_CAUSE, 32'h40);
    ack;
    chk("fixed gone", 32'h0, fault_status_bit);
    $display("multi fault test done");
    i_io_controller.pulse(B, 32'h20);
    settle;
    chk("homed", 32'h1, homed_flag);
    fev(4'd8, 4'd4, STEP_TWO, RT_REINIT, 1'b1);
    chk("enc lost", 32'h0, homed_flag);
    chk("code", 32'h6c, node_error_code);
    ack;
    chk("reinit", 32'h1, reinit_req);
    for (int k = 0; reinit_req === 1'b1; k++) begin
      if (k > 100) begin
        n_mismatch++;
        complete_run;
      end
      @(posedge pclk);
    end
    settle;
    chk("reinit done", 32'h0, fault_status_bit);
    chk("rehome", 32'h0, homed_flag);
    fev(4'd4, 4'd0, STEP_ONE, RT_POFF, 1'b0);
    ack;
    chk("poff", 32'h1, fault_status_bit);
    i_io_controller.pulse(B, 32'h10);
    settle;
    chk("restart", 32'h0, fault_status_bit);
    wr(`ADDR_SEVCFG, 32'h8);
    i_io_controller.xfer(1'b0, `ADDR_SEVCFG, 32'h0, q, e);
    chk("cfg rd", 32'h8, q);
    wr(`ADDR_EVENT, 32'h1031);
    settle;
    chk("cfg step", 32'h1, fault_status_bit);
    $display("recovery test done");
    fev(4'd5, 4'd1, STEP_SYS, RT_POFF, 1'b0);
    chk("halt", 32'h1, system_halted);
    fev(4'd3, 4'd2, STEP_WARN, RT_RESET, 1'b0);
    chk("frozen", 32'h0, warning_status_bit);
    chk("hang", 32'h0, i_io_controller.n_hang);
    $display("halt test done");
    complete_run;
  end
endmodule
`default_nettype wire
